// ### verilog/acc_pkg.sv
// shared constants, field layouts and carrier types of the comparator control block
package acc_pkg;

    // ======================================================================
    // input multiplexer
    // ======================================================================
    localparam int          N_CH       = 8;
    localparam int          SEL_W      = 4;
    localparam logic [3:0]  SEL_INT    = 4'h8;  // positive: regulator, negative: ground
    localparam logic [3:0]  SEL_RST    = 4'hF;  // no connection

    // ======================================================================
    // response time and hysteresis
    // ======================================================================
    localparam int          RESP_W     = 2;
    localparam logic [1:0]  RESP_RST   = 2'h2;
    localparam int          HYST_W     = 2;
    localparam logic [1:0]  HYST_OFF   = 2'h0;
    localparam logic [1:0]  HYST_5MV   = 2'h1;
    localparam logic [1:0]  HYST_10MV  = 2'h2;
    localparam logic [1:0]  HYST_20MV  = 2'h3;

    // ======================================================================
    // reset values of the held state
    // ======================================================================
    localparam logic        EN_RST     = 1'b0;
    localparam logic        FLAG_RST   = 1'b0;
    localparam logic        OUT_RST    = 1'b0;
    localparam logic [1:0]  RST_SYNC_0 = 2'h0;

    // ======================================================================
    // carriers
    // ======================================================================
    typedef struct packed {
        logic                en;
        logic [SEL_W-1:0]    pos_input_select;
        logic [SEL_W-1:0]    neg_input_select;
        logic [RESP_W-1:0]   resp_mode;
        logic [HYST_W-1:0]   pos_hysteresis_field;
        logic [HYST_W-1:0]   neg_hysteresis_field;
        logic                rising_irq_enable;
        logic                falling_irq_enable;
    } acc_cfg_t;

    typedef struct packed {
        logic                pwr_en;
        logic [N_CH-1:0]     pos_ch;
        logic                pos_ldo;
        logic [N_CH-1:0]     neg_ch;
        logic                neg_gnd;
        logic [RESP_W-1:0]   resp_mode;
        logic [HYST_W-1:0]   hyst_pos;
        logic [HYST_W-1:0]   hyst_neg;
    } acc_ana_t;

    localparam acc_ana_t ANA_RST = '{pwr_en: EN_RST, pos_ch: '0, pos_ldo: 1'b0, neg_ch: '0,
                                     neg_gnd: 1'b0, resp_mode: RESP_RST, hyst_pos: HYST_OFF,
                                     hyst_neg: HYST_OFF};

    typedef struct packed {
        acc_ana_t            ana;
        logic                out_q;
        logic                rise_q;
        logic                fall_q;
    } acc_st_t;

    typedef struct packed {
        logic                s1;
        logic                s2;
        logic                prev;
    } acc_sync_st_t;

endpackage : acc_pkg

// ### verilog/acc_mux_dec.sv
// decoder from a multiplexer code to one-hot channel and internal-node selects
`timescale 1ns/1ps
module acc_mux_dec
    import acc_pkg::*;
#(
    parameter int N = acc_pkg::N_CH
) (
    input  wire logic [acc_pkg::SEL_W-1:0] sel,
    output logic      [N-1:0]              ch,
    output logic                           int_sel
);
    import acc_pkg::*;

    // ======================================================================
    // per channel decode
    // ======================================================================
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_ch
            assign ch[i] = (sel == SEL_W'(i));
        end
    endgenerate

    // codes above the internal node select nothing
    assign int_sel = (sel == SEL_INT);

endmodule : acc_mux_dec

// ### verilog/acc_sync.sv
// two-stage synchroniser of the raw comparator level with edge detection
`timescale 1ns/1ps
module acc_sync
    import acc_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic ce,
    input  wire logic din,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    import acc_pkg::*;

    acc_sync_st_t st_q;
    acc_sync_st_t st_d;

    // ======================================================================
    // next state
    // ======================================================================
    always_comb begin
        st_d      = st_q;
        st_d.s1   = din;
        st_d.s2   = st_q.s1;
        st_d.prev = st_q.s2;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    assign level = st_q.s2;
    assign rise  = st_q.s2 & ~st_q.prev;
    assign fall  = ~st_q.s2 & st_q.prev;

    // ======================================================================
    // checks
    // ======================================================================
    a_sync_two_stage: assert property (@(posedge clk) disable iff (!rst_n) // [R17]
        ce && din ##1 ce |=> level)
        else $error("synchroniser did not pass a high level in two stages");

    a_edge_exclusive: assert property (@(posedge clk) disable iff (!rst_n) // [R17]
        !(rise && fall))
        else $error("rise and fall seen together");

endmodule : acc_sync

// ### verilog/acc_top.sv
// control and status logic around the analog comparator
//
// Operation
// [R1] positive select: channels 0-7, regulator, none
// [R2] negative select: channels 0-7, ground, none
// [R3] synchronised and raw outputs both provided
// [R4] raw output works without system clock
// [R5] disabled comparator drives outputs low
// [R6] software selects response time mode
// [R7] negative hysteresis: 20, 10, 5 mV, off
// [R8] positive hysteresis selected the same way
// [R9] falling edge sets falling flag
// [R10] rising edge sets rising flag
// [R11] flags stay set until software clears
// [R12] rising flag gated by rising enable
// [R13] falling flag gated by falling enable
// [R14] status bit shows current output state
// [R15] enable bit powers comparator on or off
// [R16] software clears flags after setting changes
// [R17] edges and output use two-stage synchroniser
// [R18] request is OR of flag AND enable
`timescale 1ns/1ps
module acc_top
    import acc_pkg::*;
(
    input  wire logic             CLK_SYS,
    input  wire logic             RST_B,
    input  wire logic             CE,
    input  wire acc_pkg::acc_cfg_t CFG,
    input  wire logic             RISE_CLR,
    input  wire logic             FALL_CLR,
    input  wire logic             CMP_RAW,
    output acc_pkg::acc_ana_t     ANA,
    output logic                  SYNC_OUT,
    output logic                  RAW_OUT,
    output logic                  OUT_STATE,
    output logic                  RISE_FLAG,
    output logic                  FALL_FLAG,
    output logic                  IRQ
);
    import acc_pkg::*;

    // ======================================================================
    // reset release
    // ======================================================================
    logic [1:0]      rst_sync_q;
    logic            rst_n;

    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            rst_sync_q <= RST_SYNC_0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_q[1];

    // ======================================================================
    // declarations
    // ======================================================================
    acc_st_t         st_q;
    acc_st_t         st_d;
    logic [N_CH-1:0] pos_ch;
    logic            pos_ldo;
    logic [N_CH-1:0] neg_ch;
    logic            neg_gnd;
    logic            cmp_level;
    logic            cmp_rise;
    logic            cmp_fall;
    logic            en_q;

    assign en_q = st_q.ana.pwr_en;

    // ======================================================================
    // input multiplexer decode
    // ======================================================================
    acc_mux_dec #(
        .N       (N_CH)
    ) u_pos_dec (
        .sel     (CFG.pos_input_select),
        .ch      (pos_ch),
        .int_sel (pos_ldo)
    );

    acc_mux_dec #(
        .N       (N_CH)
    ) u_neg_dec (
        .sel     (CFG.neg_input_select),
        .ch      (neg_ch),
        .int_sel (neg_gnd)
    );

    // ======================================================================
    // comparator result synchroniser
    // ======================================================================
    acc_sync u_sync (
        .clk     (CLK_SYS),
        .rst_n   (rst_n),
        .ce      (CE),
        .din     (CMP_RAW),
        .level   (cmp_level),
        .rise    (cmp_rise),
        .fall    (cmp_fall)
    );

    // ======================================================================
    // next state
    // ======================================================================
    always_comb begin
        st_d                = st_q;
        st_d.ana.pwr_en     = CFG.en;                    // [R15]
        st_d.ana.pos_ch     = pos_ch;                    // [R1]
        st_d.ana.pos_ldo    = pos_ldo;                   // [R1]
        st_d.ana.neg_ch     = neg_ch;                    // [R2]
        st_d.ana.neg_gnd    = neg_gnd;                   // [R2]
        st_d.ana.resp_mode  = CFG.resp_mode;             // [R6]
        st_d.ana.hyst_neg   = CFG.neg_hysteresis_field;  // [R7]
        st_d.ana.hyst_pos   = CFG.pos_hysteresis_field;  // [R8]
        // registered copy of the synchronised level, held low while off
        st_d.out_q          = cmp_level & en_q;          // [R3] [R5] [R17]
        // flags cleared only by software or reset; a same-cycle edge beats the clear
        if (RISE_CLR) begin
            st_d.rise_q = 1'b0;                          // [R11]
        end
        if (FALL_CLR) begin
            st_d.fall_q = 1'b0;                          // [R11]
        end
        if (en_q && cmp_rise) begin
            st_d.rise_q = 1'b1;                          // [R10]
        end
        if (en_q && cmp_fall) begin
            st_d.fall_q = 1'b1;                          // [R9]
        end
    end

    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '{ana: ANA_RST, out_q: OUT_RST, rise_q: FLAG_RST, fall_q: FLAG_RST};
        end else if (CE) begin
            st_q <= st_d;
        end
    end

    // ======================================================================
    // outputs
    // ======================================================================
    assign ANA       = st_q.ana;
    assign SYNC_OUT  = st_q.out_q;                       // [R3]
    // raw path bypasses the synchroniser, gated only by the registered enable, so it keeps working with the clock stopped
    assign RAW_OUT   = CMP_RAW & en_q;                   // [R3] [R4] [R5]
    assign OUT_STATE = st_q.out_q;                       // [R14]
    assign RISE_FLAG = st_q.rise_q;
    assign FALL_FLAG = st_q.fall_q;
    assign IRQ       = (st_q.rise_q & CFG.rising_irq_enable)    // [R12] [R18]
                     | (st_q.fall_q & CFG.falling_irq_enable);  // [R13] [R18]

    // ======================================================================
    // checks
    // ======================================================================
    default clocking cb @(posedge CLK_SYS);
    endclocking

    default disable iff (!rst_n);

    a_pos_chan_route: assert property ( // [R1]
        CE && !CFG.pos_input_select[3]
        |=> ANA.pos_ch == (8'h01 << $past(CFG.pos_input_select[2:0])) && !ANA.pos_ldo)
        else $error("positive channel select wrong");

    a_pos_ldo_none: assert property ( // [R1]
        CE && CFG.pos_input_select[3]
        |=> ANA.pos_ch == 8'h00 && ANA.pos_ldo == ($past(CFG.pos_input_select) == 4'h8))
        else $error("positive regulator or no-connect select wrong");

    a_neg_chan_route: assert property ( // [R2]
        CE && !CFG.neg_input_select[3]
        |=> ANA.neg_ch == (8'h01 << $past(CFG.neg_input_select[2:0])) && !ANA.neg_gnd)
        else $error("negative channel select wrong");

    a_neg_gnd_none: assert property ( // [R2]
        CE && CFG.neg_input_select[3]
        |=> ANA.neg_ch == 8'h00 && ANA.neg_gnd == ($past(CFG.neg_input_select) == 4'h8))
        else $error("negative ground or no-connect select wrong");

    a_sync_out_delay: assert property ( // [R3]
        CE && en_q && CMP_RAW ##1 CE && en_q ##1 CE && en_q |=> SYNC_OUT)
        else $error("synchronised output missed a high level after three cycles");

    a_status_low_delay: assert property ( // [R14]
        CE && en_q && !CMP_RAW ##1 CE && en_q ##1 CE && en_q |=> !OUT_STATE)
        else $error("status bit did not follow a low comparator result");

    a_off_outputs_low: assert property ( // [R5]
        !en_q && $past(!en_q) |-> !SYNC_OUT && !RAW_OUT)
        else $error("outputs not low while comparator disabled");

    a_raw_follows: assert property ( // [R4]
        en_q && CMP_RAW |-> RAW_OUT)
        else $error("raw output did not follow the comparator");

    a_enable_power: assert property ( // [R15]
        CE |=> ANA.pwr_en == $past(CFG.en))
        else $error("comparator power does not follow the enable bit");

    a_mode_fields: assert property ( // [R6]
        CE |=> ANA.resp_mode == $past(CFG.resp_mode)
            && ANA.hyst_neg == $past(CFG.neg_hysteresis_field)
            && ANA.hyst_pos == $past(CFG.pos_hysteresis_field))
        else $error("response or hysteresis setting not applied");

    a_rise_flag_set: assert property ( // [R10]
        CE && en_q && cmp_rise |=> RISE_FLAG)
        else $error("rising edge did not set the rising flag");

    a_fall_flag_set: assert property ( // [R9]
        CE && en_q && cmp_fall |=> FALL_FLAG)
        else $error("falling edge did not set the falling flag");

    a_rise_sticky: assert property ( // [R11]
        RISE_FLAG && !(CE && RISE_CLR) |=> RISE_FLAG)
        else $error("rising flag dropped without a clear");

    a_fall_sticky: assert property ( // [R11]
        FALL_FLAG && !(CE && FALL_CLR) |=> FALL_FLAG)
        else $error("falling flag dropped without a clear");

    a_rise_clear: assert property ( // [R11]
        CE && RISE_CLR && !(en_q && cmp_rise) |=> !RISE_FLAG)
        else $error("rising flag clear ignored");

    a_irq_rise_gate: assert property ( // [R12]
        RISE_FLAG && CFG.rising_irq_enable |-> IRQ)
        else $error("enabled rising flag did not request");

    a_irq_fall_gate: assert property ( // [R13]
        FALL_FLAG && CFG.falling_irq_enable |-> IRQ)
        else $error("enabled falling flag did not request");

    a_irq_masked: assert property ( // [R18]
        !(RISE_FLAG && CFG.rising_irq_enable) && !(FALL_FLAG && CFG.falling_irq_enable) |-> !IRQ)
        else $error("request raised with no enabled flag");

    // ======================================================================
    // checks of flag clear and causes, edge pulses, output timing, one-hot selects and freezing
    // ======================================================================
    a_fall_clear: assert property ( // [R11]
        CE && FALL_CLR && !(en_q && cmp_fall) |=> !FALL_FLAG)
        else $error("falling flag clear ignored");

    a_rise_cause: assert property ( // [R10]
        $rose(RISE_FLAG) |-> $past(CE && en_q && cmp_rise))
        else $error("rising flag set without a rising edge");

    a_fall_cause: assert property ( // [R9]
        $rose(FALL_FLAG) |-> $past(CE && en_q && cmp_fall))
        else $error("falling flag set without a falling edge");

    a_rise_needs_en: assert property ( // [R15]
        CE && !en_q && !RISE_FLAG |=> !RISE_FLAG)
        else $error("rising flag set while comparator disabled");

    a_fall_needs_en: assert property ( // [R15]
        CE && !en_q && !FALL_FLAG |=> !FALL_FLAG)
        else $error("falling flag set while comparator disabled");

    a_rise_pulse: assert property ( // [R17]
        CE && cmp_rise |=> !cmp_rise)
        else $error("rising edge seen on two clocks");

    a_fall_pulse: assert property ( // [R17]
        CE && cmp_fall |=> !cmp_fall)
        else $error("falling edge seen on two clocks");

    a_sync_level_out: assert property ( // [R3]
        CE && en_q |=> SYNC_OUT == $past(cmp_level))
        else $error("synchronised output does not follow the second stage");

    a_status_follows: assert property ( // [R14]
        CE && en_q |=> OUT_STATE == $past(cmp_level))
        else $error("status bit does not follow the second stage");

    a_sync_out_off: assert property ( // [R5]
        CE && !en_q |=> !SYNC_OUT)
        else $error("synchronised output high after a disabled clock");

    a_raw_low_off: assert property ( // [R5]
        !en_q |-> !RAW_OUT)
        else $error("raw output high while comparator disabled");

    a_pos_onehot: assert property ( // [R1]
        $onehot0({ANA.pos_ch, ANA.pos_ldo}))
        else $error("more than one positive input selected");

    a_neg_onehot: assert property ( // [R2]
        $onehot0({ANA.neg_ch, ANA.neg_gnd}))
        else $error("more than one negative input selected");

    a_flags_frozen: assert property ( // [R11]
        !CE |=> $stable(RISE_FLAG) && $stable(FALL_FLAG))
        else $error("edge flag changed while clock enable low");

    a_ana_frozen: assert property ( // [R15]
        !CE |=> $stable(ANA))
        else $error("analog controls changed while clock enable low");

endmodule : acc_top

// ### test/acc_top_tb_top.sv
// self-checking testbench of the comparator control block
`timescale 1ns/1ps
module acc_top_tb_top;
    import acc_pkg::*;

    // ======================================================================
    // signals and counters
    // ======================================================================
    logic      clk_sys;
    logic      rst_b;
    logic      ce;
    acc_cfg_t  cfg;
    logic      rise_clr;
    logic      fall_clr;
    logic      cmp_raw;
    acc_ana_t  ana;
    logic      sync_out;
    logic      raw_out;
    logic      out_state;
    logic      rise_flag;
    logic      fall_flag;
    logic      irq;
    int        n_mismatch = 0;
    int        cmp_count  = 0;
    integer    seed       = 32'h0d73c798;
    logic      er;
    logic      ef;
    logic      es;
    acc_ana_t  held;

    acc_top dut_u (
        .CLK_SYS   (clk_sys),
        .RST_B     (rst_b),
        .CE        (ce),
        .CFG       (cfg),
        .RISE_CLR  (rise_clr),
        .FALL_CLR  (fall_clr),
        .CMP_RAW   (cmp_raw),
        .ANA       (ana),
        .SYNC_OUT  (sync_out),
        .RAW_OUT   (raw_out),
        .OUT_STATE (out_state),
        .RISE_FLAG (rise_flag),
        .FALL_FLAG (fall_flag),
        .IRQ       (irq)
    );

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // ======================================================================
    // expectations and helpers
    // ======================================================================
    function automatic acc_ana_t exp_ana(input acc_cfg_t c);
        acc_ana_t a;
        a.pwr_en    = c.en;
        a.pos_ch    = (c.pos_input_select < 4'h8) ? (8'h01 << c.pos_input_select) : 8'h00;
        a.pos_ldo   = (c.pos_input_select == 4'h8);
        a.neg_ch    = (c.neg_input_select < 4'h8) ? (8'h01 << c.neg_input_select) : 8'h00;
        a.neg_gnd   = (c.neg_input_select == 4'h8);
        a.resp_mode = c.resp_mode;
        a.hyst_pos  = c.pos_hysteresis_field;
        a.hyst_neg  = c.neg_hysteresis_field;
        return a;
    endfunction : exp_ana

    function automatic logic exp_irq();
        return (er & cfg.rising_irq_enable) | (ef & cfg.falling_irq_enable);
    endfunction : exp_irq

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at time %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : tick

    task automatic edge_step(input logic v);
        cmp_raw = v;
        #1;
        check(raw_out, v & cfg.en, "raw out");
        tick(2);
        check(sync_out, es, "sync early");
        tick(1);
        if (cfg.en) begin
            if (v & !es) er = 1'b1;
            if (!v & es) ef = 1'b1;
            es = v;
        end
        check(sync_out, es, "sync out");
        check(out_state, es, "status bit");
        check(rise_flag, er, "rise flag");
        check(fall_flag, ef, "fall flag");
        check(irq, exp_irq(), "irq");
    endtask : edge_step

    task automatic clr(input logic r, input logic f);
        rise_clr = r;
        fall_clr = f;
        tick(1);
        rise_clr = 1'b0;
        fall_clr = 1'b0;
        if (r) er = 1'b0;
        if (f) ef = 1'b0;
        check(rise_flag, er, "rise clear");
        check(fall_flag, ef, "fall clear");
        check(irq, exp_irq(), "irq after clear");
        // let an edge pass so a following clear never re-raises a strobe in the same step
        tick(1);
    endtask : clr

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        #(25 * 5000);
        n_mismatch++;
        tally_and_finish();
    end

    // ======================================================================
    // tests
    // ======================================================================
    initial begin
        rst_b    = 1'b0;
        ce       = 1'b1;
        cfg      = '0;
        rise_clr = 1'b0;
        fall_clr = 1'b0;
        cmp_raw  = 1'b0;
        er       = 1'b0;
        ef       = 1'b0;
        es       = 1'b0;
        tick(3);
        check(ana, ANA_RST, "reset ana");
        check({sync_out, raw_out, rise_flag, fall_flag, irq}, 5'h00, "reset outputs");
        rst_b = 1'b1;
        tick(3);
        $display("test reset done");

        // every code on both selectors, back to back, with random response mode and interrupt enables
        for (int i = 0; i < 16; i++) begin
            cfg.en                   = i[0];
            cfg.pos_input_select     = i[3:0];
            cfg.neg_input_select     = 4'hF - i[3:0];
            cfg.resp_mode            = 2'($random(seed));
            cfg.pos_hysteresis_field = i[1:0];
            cfg.neg_hysteresis_field = ~i[1:0];
            cfg.rising_irq_enable    = 1'($random(seed));
            cfg.falling_irq_enable   = 1'($random(seed));
            tick(1);
            check(ana, exp_ana(cfg), "ana decode");
        end
        $display("test mux done");

        cfg.en = 1'b1;
        tick(1);
        clr(1'b1, 1'b1);
        edge_step(1'b1);
        edge_step(1'b0);
        for (int m = 0; m < 4; m++) begin
            cfg.rising_irq_enable  = m[0];
            cfg.falling_irq_enable = m[1];
            #1;
            check(irq, exp_irq(), "irq mask");
            tick(1);
        end
        tick(5);
        check({rise_flag, fall_flag}, {er, ef}, "flags sticky");
        clr(1'b1, 1'b0);
        clr(1'b0, 1'b1);
        for (int k = 0; k < 24; k++) begin
            edge_step(1'($random(seed)));
            if (k % 5 == 4) clr(1'($random(seed)), 1'($random(seed)));
        end
        $display("test edges done");

        // state frozen by clock enable while the raw output keeps working
        edge_step(1'b1);
        held = ana;
        ce = 1'b0;
        cfg.pos_input_select = cfg.pos_input_select ^ 4'h1;
        cmp_raw = 1'b0;
        #1;
        check(raw_out, 1'b0, "raw without clock");
        cmp_raw = 1'b1;
        #1;
        check(raw_out, 1'b1, "raw without clock");
        tick(2);
        check(ana, held, "ana frozen");
        check(sync_out, es, "sync frozen");
        ce = 1'b1;
        tick(1);
        check(ana, exp_ana(cfg), "ana after freeze");
        $display("test freeze done");

        cfg.en = 1'b0;
        tick(2);
        es = 1'b0;
        check(ana.pwr_en, 1'b0, "power off");
        check({sync_out, raw_out, out_state}, 3'h0, "disabled outputs");
        edge_step(1'b0);
        edge_step(1'b1);
        $display("test disable done");

        rst_b = 1'b0;
        #1;
        check(ana, ANA_RST, "mid reset ana");
        check({sync_out, rise_flag, fall_flag, irq}, 4'h0, "mid reset outputs");
        tick(3);
        rst_b = 1'b1;
        tick(3);
        er = 1'b0;
        ef = 1'b0;
        check(ana, exp_ana(cfg), "ana after second reset");
        check({sync_out, out_state, rise_flag, fall_flag, irq}, 5'h00, "outputs after second reset");
        // enabling with the input high raises a spurious rising flag, so clear after it
        cfg.en = 1'b1;
        es     = 1'b1;
        tick(3);
        clr(1'b1, 1'b1);
        edge_step(1'b0);
        $display("test second reset done");
        tally_and_finish();
    end

endmodule : acc_top_tb_top
